//--- csb_params.svh
/*
 * Constants for the compare, skip and branch unit: flag positions,
 * widths, cycle costs and program counter steps.
 * Assumes it is included by bare name from the flag generator, the unit and the bench.
 */
`ifndef CSB_PARAMS_SVH
`define CSB_PARAMS_SVH

// ********************************************************************
// Widths
// ********************************************************************
`define CSB_DATA_W     8
`define CSB_PC_W       16
`define CSB_OFS_W      7
`define CSB_BIT_W      3
`define CSB_CNT_W      2

// ********************************************************************
// Status flag positions and reset value
// ********************************************************************
`define CSB_FLAG_C     0
`define CSB_FLAG_Z     1
`define CSB_FLAG_N     2
`define CSB_FLAG_V     3
`define CSB_FLAG_S     4
`define CSB_FLAG_H     5
`define CSB_FLAG_T     6
`define CSB_FLAG_I     7
`define CSB_FLAGS_RST  8'h00
`define CSB_MSB        7
`define CSB_NIB_MSB    3

// ********************************************************************
// Program counter steps and extra cycle counts
// ********************************************************************
`define CSB_PC_STEP1   16'h0001
`define CSB_PC_STEP2   16'h0002
`define CSB_PC_STEP3   16'h0003
`define CSB_PC_RST     16'h0000
`define CSB_EXTRA0     2'h0
`define CSB_EXTRA1     2'h1
`define CSB_EXTRA2     2'h2
`define CSB_LAST       2'h1

`endif

//--- csb_pkg.sv
/*
 * Types shared by the compare, skip and branch unit.
 * Assumes csb_params.svh is available for the design files.
 */
package csb_pkg;

	// Instruction selected by the decoder in front of this unit
	typedef enum logic [3:0] {
		CSB_OP_NONE,
		CSB_OP_COMPARE_SKIP_EQUAL,
		CSB_OP_COMPARE_REGS,
		CSB_OP_COMPARE_REGS_WITH_CARRY,
		CSB_OP_COMPARE_IMMEDIATE,
		CSB_OP_SKIP_REG_BIT_CLEAR,
		CSB_OP_SKIP_REG_BIT_SET,
		CSB_OP_SKIP_IO_BIT_CLEAR,
		CSB_OP_SKIP_IO_BIT_SET,
		CSB_OP_BRANCH_FLAG_SET,
		CSB_OP_BRANCH_FLAG_CLEAR,
		CSB_OP_BRANCH_ZERO_SET,
		CSB_OP_BRANCH_ZERO_CLEAR,
		CSB_OP_BRANCH_CARRY_SET,
		CSB_OP_BRANCH_CARRY_CLEAR,
		CSB_OP_BRANCH_SAME_HIGHER
	} csb_op_t;

	// Sequencer states
	typedef enum logic {
		CSB_ST_IDLE,
		CSB_ST_HOLD
	} csb_state_t;

endpackage

//--- csb_cmp_flags.sv
/*
 * Subtract-without-store flag generator for the compare instructions.
 * Assumes operands are stable in the cycle they are used; purely combinational.
 */
`timescale 1ns/1ps
`include "csb_params.svh"

module csb_cmp_flags (
	input  wire logic [`CSB_DATA_W-1:0] a,         // Minuend
	input  wire logic [`CSB_DATA_W-1:0] b,         // Subtrahend
	input  wire logic                   use_carry, // Subtract old carry too
	input  wire logic                   old_c,     // Carry before the compare
	input  wire logic                   old_z,     // Zero before the compare
	output logic                        flag_c,    // Borrow out
	output logic                        flag_z,    // Zero result
	output logic                        flag_n,    // Result sign
	output logic                        flag_v,    // Two's complement overflow
	output logic                        flag_s,    // Sign test, n xor v
	output logic                        flag_h     // Borrow from low nibble
);

	logic [`CSB_DATA_W:0]   diff;
	logic [`CSB_DATA_W-1:0] r;
	logic                   cin;

	// Full-width difference; the result itself is thrown away here, only flags are output
	always_comb begin
		cin    = use_carry & old_c;
		diff   = {1'b0, a} - {1'b0, b} - {{`CSB_DATA_W{1'b0}}, cin};
		r      = diff[`CSB_DATA_W-1:0];
		flag_c = diff[`CSB_DATA_W];
		flag_n = r[`CSB_MSB];
		flag_v = (a[`CSB_MSB] & ~b[`CSB_MSB] & ~r[`CSB_MSB])
		       | (~a[`CSB_MSB] & b[`CSB_MSB] & r[`CSB_MSB]);
		flag_s = flag_n ^ flag_v;
		flag_h = (~a[`CSB_NIB_MSB] & b[`CSB_NIB_MSB])
		       | (b[`CSB_NIB_MSB] & r[`CSB_NIB_MSB])
		       | (r[`CSB_NIB_MSB] & ~a[`CSB_NIB_MSB]);
		// With carry, zero only sticks so multi-byte compares chain correctly
		flag_z = (r == {`CSB_DATA_W{1'b0}}) & (~use_carry | old_z);
	end

endmodule // csb_cmp_flags

//--- csb_unit.sv
/*
 * Compare, conditional skip and conditional branch execution unit.
 * Assumes a decoder presents one instruction with START for one cycle, and
 * that the fetch path tells whether the instruction after a skip is two words.
 */
`timescale 1ns/1ps
`include "csb_params.svh"

module csb_unit (
	input  wire logic                   MCLK,         // Core clock, 100 MHz
	input  wire logic                   ARST_N,       // Async reset, active low
	input  wire logic                   START,        // Instruction valid pulse
	input  wire csb_pkg::csb_op_t       OP,           // Decoded instruction
	input  wire logic [`CSB_DATA_W-1:0] RD_VAL,       // First working register
	input  wire logic [`CSB_DATA_W-1:0] RR_VAL,       // Second register or immediate
	input  wire logic [`CSB_DATA_W-1:0] IO_VAL,       // Addressed I/O register
	input  wire logic [`CSB_BIT_W-1:0]  BIT_SEL,      // Bit or flag index
	input  wire logic [`CSB_OFS_W-1:0]  OFFSET,       // Signed branch offset
	input  wire logic [`CSB_PC_W-1:0]   PC_IN,        // Address of this instruction
	input  wire logic                   NEXT_TWO_WORD,// Next instruction is two words
	input  wire logic                   FLAGS_LOAD,   // Core writes status flags
	input  wire logic [`CSB_DATA_W-1:0] FLAGS_IN,     // Value for that write
	output logic                        BUSY,         // Extra cycles in progress
	output logic                        DONE,         // Instruction finished pulse
	output logic                        TAKEN,        // Branch taken or skip done
	output logic [`CSB_PC_W-1:0]        PC_OUT,       // Next program counter
	output logic [`CSB_DATA_W-1:0]      STATUS_FLAGS  // status_flags_register
);
	import csb_pkg::*;

	// ****************************************************************
	// Declarations
	// ****************************************************************
	csb_state_t                state_reg;
	logic [`CSB_CNT_W-1:0]     rem_reg;
	logic [`CSB_CNT_W-1:0]     extra_next;
	logic                      busy_reg;
	logic                      done_reg;
	logic                      taken_reg;
	logic                      taken_next;
	logic [`CSB_PC_W-1:0]      pc_reg;
	logic [`CSB_PC_W-1:0]      pc_next;
	logic [`CSB_PC_W-1:0]      pc_hold_reg;
	logic [`CSB_DATA_W-1:0]    flags_reg;
	logic [`CSB_DATA_W-1:0]    flags_next;
	logic                      accept;
	logic                      is_cmp;
	logic                      is_skip;
	logic                      is_branch;
	logic                      cond;
	logic [`CSB_PC_W-1:0]      ofs_ext;
	logic                      f_c;
	logic                      f_z;
	logic                      f_n;
	logic                      f_v;
	logic                      f_s;
	logic                      f_h;

	// New work is only taken while idle; START during BUSY is dropped
	assign accept = START && (state_reg == CSB_ST_IDLE) && (OP != CSB_OP_NONE);

	// ****************************************************************
	// Flag generation for compares
	// ****************************************************************
	csb_cmp_flags u_flags (
		.a         (RD_VAL),
		.b         (RR_VAL),
		.use_carry (OP == CSB_OP_COMPARE_REGS_WITH_CARRY),
		.old_c     (flags_reg[`CSB_FLAG_C]),
		.old_z     (flags_reg[`CSB_FLAG_Z]),
		.flag_c    (f_c),
		.flag_z    (f_z),
		.flag_n    (f_n),
		.flag_v    (f_v),
		.flag_s    (f_s),
		.flag_h    (f_h)
	);

	// ****************************************************************
	// Decode: class, condition, next pc and cycle cost
	// ****************************************************************
	always_comb begin
		is_cmp    = 1'b0;
		is_skip   = 1'b0;
		is_branch = 1'b0;
		cond      = 1'b0;
		case (OP)
			CSB_OP_COMPARE_REGS,
			CSB_OP_COMPARE_REGS_WITH_CARRY,
			CSB_OP_COMPARE_IMMEDIATE: begin
				is_cmp = 1'b1;
			end
			CSB_OP_COMPARE_SKIP_EQUAL: begin
				is_skip = 1'b1;
				cond    = (RD_VAL == RR_VAL);
			end
			CSB_OP_SKIP_REG_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~RR_VAL[BIT_SEL];
			end
			CSB_OP_SKIP_REG_BIT_SET: begin
				is_skip = 1'b1;
				cond    = RR_VAL[BIT_SEL];
			end
			CSB_OP_SKIP_IO_BIT_CLEAR: begin
				is_skip = 1'b1;
				cond    = ~IO_VAL[BIT_SEL];
			end
			CSB_OP_SKIP_IO_BIT_SET: begin
				is_skip = 1'b1;
				cond    = IO_VAL[BIT_SEL];
			end
			CSB_OP_BRANCH_FLAG_SET: begin
				is_branch = 1'b1;
				cond      = flags_reg[BIT_SEL];
			end
			CSB_OP_BRANCH_FLAG_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~flags_reg[BIT_SEL];
			end
			CSB_OP_BRANCH_ZERO_SET: begin
				is_branch = 1'b1;
				cond      = flags_reg[`CSB_FLAG_Z];
			end
			CSB_OP_BRANCH_ZERO_CLEAR: begin
				is_branch = 1'b1;
				cond      = ~flags_reg[`CSB_FLAG_Z];
			end
			CSB_OP_BRANCH_CARRY_SET: begin
				is_branch = 1'b1;
				cond      = flags_reg[`CSB_FLAG_C];
			end
			CSB_OP_BRANCH_CARRY_CLEAR,
			CSB_OP_BRANCH_SAME_HIGHER: begin
				is_branch = 1'b1;
				cond      = ~flags_reg[`CSB_FLAG_C];
			end
			default: begin
				cond = 1'b0;
			end
		endcase
	end

	// Offset is signed, so sign-extend before adding to the pc
	assign ofs_ext = {{(`CSB_PC_W-`CSB_OFS_W){OFFSET[`CSB_OFS_W-1]}}, OFFSET};

	// Target pc and extra cycles; a skip pays one cycle per skipped word
	always_comb begin
		pc_next    = PC_IN + `CSB_PC_STEP1;
		extra_next = `CSB_EXTRA0;
		taken_next = 1'b0;
		if (is_branch && cond) begin
			pc_next    = PC_IN + ofs_ext + `CSB_PC_STEP1;
			extra_next = `CSB_EXTRA1;
			taken_next = 1'b1;
		end else if (is_skip && cond) begin
			taken_next = 1'b1;
			if (NEXT_TWO_WORD) begin
				pc_next    = PC_IN + `CSB_PC_STEP3;
				extra_next = `CSB_EXTRA2;
			end else begin
				pc_next    = PC_IN + `CSB_PC_STEP2;
				extra_next = `CSB_EXTRA1;
			end
		end
	end

	// ****************************************************************
	// Sequencer: counts the extra cycles of a taken branch or skip
	// ****************************************************************
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state_reg <= CSB_ST_IDLE;
			rem_reg   <= `CSB_EXTRA0;
		end else begin
			case (state_reg)
				CSB_ST_IDLE: begin
					if (accept && (extra_next != `CSB_EXTRA0)) begin
						state_reg <= CSB_ST_HOLD;
						rem_reg   <= extra_next;
					end
				end
				CSB_ST_HOLD: begin
					rem_reg <= rem_reg - `CSB_LAST;
					if (rem_reg == `CSB_LAST) begin
						state_reg <= CSB_ST_IDLE;
					end
				end
				default: begin
					state_reg <= CSB_ST_IDLE;
				end
			endcase
		end
	end

	// Result outputs: one-cycle DONE with the final pc and outcome
	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			busy_reg    <= 1'b0;
			done_reg    <= 1'b0;
			taken_reg   <= 1'b0;
			pc_reg      <= `CSB_PC_RST;
			pc_hold_reg <= `CSB_PC_RST;
		end else begin
			done_reg <= 1'b0;
			if (accept) begin
				pc_hold_reg <= pc_next;
				taken_reg   <= taken_next;
				if (extra_next == `CSB_EXTRA0) begin
					done_reg <= 1'b1;
					pc_reg   <= pc_next;
				end else begin
					busy_reg <= 1'b1;
				end
			end else if (state_reg == CSB_ST_HOLD && rem_reg == `CSB_LAST) begin
				busy_reg <= 1'b0;
				done_reg <= 1'b1;
				pc_reg   <= pc_hold_reg;
			end
		end
	end

	// ****************************************************************
	// Status flags: only core writes and compares touch them here
	// ****************************************************************
	always_comb begin
		flags_next = flags_reg;
		if (FLAGS_LOAD) begin
			flags_next = FLAGS_IN;
		end
		// A compare in the same cycle as a core write wins for C, Z, N, V, S and H, being newer work
		if (accept && is_cmp) begin
			flags_next[`CSB_FLAG_C] = f_c;
			flags_next[`CSB_FLAG_Z] = f_z;
			flags_next[`CSB_FLAG_N] = f_n;
			flags_next[`CSB_FLAG_V] = f_v;
			flags_next[`CSB_FLAG_S] = f_s;
			flags_next[`CSB_FLAG_H] = f_h;
		end
	end

	always_ff @(posedge MCLK or negedge ARST_N) begin
		if (!ARST_N) begin
			flags_reg <= `CSB_FLAGS_RST;
		end else begin
			flags_reg <= flags_next;
		end
	end

	assign BUSY         = busy_reg;
	assign DONE         = done_reg;
	assign TAKEN        = taken_reg;
	assign PC_OUT       = pc_reg;
	assign STATUS_FLAGS = flags_reg;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge MCLK); endclocking
	default disable iff (!ARST_N);

	sequence s_one_extra;
		busy_reg ##1 done_reg;
	endsequence

	sequence s_two_extra;
		busy_reg [*2] ##1 done_reg;
	endsequence

	chk_cmp_one_cycle: assert property (
		accept && is_cmp |=> done_reg && !busy_reg && pc_reg == $past(PC_IN) + `CSB_PC_STEP1)
		else $error("compare did not finish in one cycle");
	chk_cmp_zero_flag: assert property (
		accept && OP == CSB_OP_COMPARE_REGS
		|=> flags_reg[`CSB_FLAG_Z] == ($past(RD_VAL) == $past(RR_VAL)))
		else $error("compare zero flag wrong");
	chk_skip_eq_one: assert property (
		accept && OP == CSB_OP_COMPARE_SKIP_EQUAL && RD_VAL == RR_VAL && !NEXT_TWO_WORD
		|=> s_one_extra ##0 pc_reg == $past(PC_IN, 2) + `CSB_PC_STEP2)
		else $error("equal skip over one word wrong");
	chk_skip_reg_clr: assert property (
		accept && OP == CSB_OP_SKIP_REG_BIT_CLEAR && !RR_VAL[BIT_SEL] && NEXT_TWO_WORD
		|=> s_two_extra ##0 pc_reg == $past(PC_IN, 3) + `CSB_PC_STEP3)
		else $error("register bit clear skip over two words wrong");
	chk_skip_reg_set: assert property (
		accept && OP == CSB_OP_SKIP_REG_BIT_SET && !RR_VAL[BIT_SEL] && !FLAGS_LOAD
		|=> done_reg && !taken_reg && $stable(flags_reg))
		else $error("register bit set skip taken on zero bit");
	chk_skip_io_clr: assert property (
		accept && OP == CSB_OP_SKIP_IO_BIT_CLEAR && !FLAGS_LOAD |=> $stable(flags_reg))
		else $error("io bit clear skip changed flags");
	chk_skip_io_set: assert property (
		accept && OP == CSB_OP_SKIP_IO_BIT_SET && IO_VAL[BIT_SEL] |=> busy_reg && taken_reg)
		else $error("io bit set skip not taken");
	chk_branch_set: assert property (
		accept && OP == CSB_OP_BRANCH_FLAG_SET && flags_reg[BIT_SEL]
		|=> s_one_extra ##0 pc_reg == $past(PC_IN, 2) + $past(ofs_ext, 2) + `CSB_PC_STEP1)
		else $error("flag set branch target wrong");
	chk_branch_clear: assert property (
		accept && OP == CSB_OP_BRANCH_FLAG_CLEAR && flags_reg[BIT_SEL]
		|=> done_reg && !taken_reg && pc_reg == $past(PC_IN) + `CSB_PC_STEP1)
		else $error("flag clear branch fell through wrong");
	chk_branch_zero: assert property (
		accept && OP == CSB_OP_BRANCH_ZERO_CLEAR |=> taken_reg == !$past(flags_reg[`CSB_FLAG_Z]))
		else $error("zero clear branch decision wrong");
	chk_branch_carry: assert property (
		accept && OP == CSB_OP_BRANCH_CARRY_SET |=> taken_reg == $past(flags_reg[`CSB_FLAG_C]))
		else $error("carry set branch decision wrong");
	chk_same_higher: assert property (
		accept && OP == CSB_OP_BRANCH_SAME_HIGHER && !FLAGS_LOAD
		|=> taken_reg == !$past(flags_reg[`CSB_FLAG_C]) && $stable(flags_reg))
		else $error("same or higher branch wrong");
	chk_busy_cost: assert property (
		busy_reg |-> ##[1:2] done_reg)
		else $error("extra cycles exceed two");

endmodule // csb_unit

//--- csb_fetch_model.sv
/*
 * Fetch path model: says whether the word after a skip starts a
 * two-word instruction.
 * Assumes the unit asks about the pc of the skip being run.
 */
`timescale 1ns/1ps

module csb_fetch_model (
	input  wire logic [15:0] pc,       // Address of the skip
	output logic             two_word  // Next instruction is two words
);
	// Long opcodes where pc+1 is a multiple of 3, so both sizes occur
	assign two_word = (((pc + 16'h0001) % 16'h0003) == 16'h0000);
endmodule // csb_fetch_model

//--- tb_compare_skip_branch_unit.sv
/*
 * Self-checking bench for csb_unit: issues decoded instructions, checks
 * pc, outcome, cycle count and flags.
 * Assumes csb_fetch_model answers the two-word question.
 */
`timescale 1ns/1ps
`include "csb_params.svh"

module tb_compare_skip_branch_unit;
	import csb_pkg::*;
	logic        mclk, arst_n, start, two, flags_load, busy, done, taken;
	csb_op_t     op;
	logic [7:0]  rd, rr, io, flags_in, flags, ef;
	logic [2:0]  bs;
	logic [6:0]  ofs;
	logic [15:0] pc, pc_out;
	int          mismatches, total_checks, cycles, n;
	logic [15:0] cv [6] = '{16'h1010, 16'h0001, 16'h8001, 16'h1809, 16'h7f80, 16'h0000};

	csb_unit i_dut (.MCLK(mclk), .ARST_N(arst_n), .START(start), .OP(op), .RD_VAL(rd),
		.RR_VAL(rr), .IO_VAL(io), .BIT_SEL(bs), .OFFSET(ofs), .PC_IN(pc),
		.NEXT_TWO_WORD(two), .FLAGS_LOAD(flags_load), .FLAGS_IN(flags_in),
		.BUSY(busy), .DONE(done), .TAKEN(taken), .PC_OUT(pc_out), .STATUS_FLAGS(flags));
	csb_fetch_model i_fetch (.pc(pc), .two_word(two));

	// ****************************************************************
	// Clock, timeout and reporting
	// ****************************************************************
	// Free running core clock
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	// Under 200 ops of at most 5 cycles each; a hang ends the run
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			wrap_up();
		end
	end

	task automatic check(input string what, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", what, exp, seen);
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************************************
	// Access tasks
	// ****************************************************************
	function automatic logic long_next(input logic [15:0] p);
		return ((p + 16'h0001) % 16'h0003) == 16'h0000;
	endfunction

	// Condition of each skip or branch, from the flags before it
	function automatic logic cond(input csb_op_t o, input logic [7:0] f);
		case (o)
			CSB_OP_COMPARE_SKIP_EQUAL:  return rd == rr;
			CSB_OP_SKIP_REG_BIT_CLEAR:  return !rr[bs];
			CSB_OP_SKIP_REG_BIT_SET:    return rr[bs];
			CSB_OP_SKIP_IO_BIT_CLEAR:   return !io[bs];
			CSB_OP_SKIP_IO_BIT_SET:     return io[bs];
			CSB_OP_BRANCH_FLAG_SET:     return f[bs];
			CSB_OP_BRANCH_FLAG_CLEAR:   return !f[bs];
			CSB_OP_BRANCH_ZERO_SET:     return f[`CSB_FLAG_Z];
			CSB_OP_BRANCH_ZERO_CLEAR:   return !f[`CSB_FLAG_Z];
			CSB_OP_BRANCH_CARRY_SET:    return f[`CSB_FLAG_C];
			default:                    return !f[`CSB_FLAG_C];
		endcase
	endfunction

	task automatic load_flags(input logic [7:0] v);
		@(negedge mclk);
		flags_load = 1'b1;
		flags_in = v;
		@(negedge mclk);
		flags_load = 1'b0;
		ef = v;
		check("flags write", {8'h00, flags}, {8'h00, v});
	endtask

	// START covers one rising edge only, then DONE is awaited
	task automatic run(input csb_op_t o, input logic [15:0] p, input logic tk,
		input logic [15:0] ep, input int en);
		@(negedge mclk);
		start = 1'b1;
		op = o;
		pc = p;
		@(negedge mclk);
		start = 1'b0;
		n = 1;
		check("busy", {15'h0, busy}, {15'h0, (en > 1)});
		while (done !== 1'b1 && n < 6) begin
			@(negedge mclk);
			n++;
		end
		check("cycles", n[15:0], en[15:0]);
		check("taken", {15'h0, taken}, {15'h0, tk});
		check("pc", pc_out, ep);
		check("flags", {8'h00, flags}, {8'h00, ef});
	endtask

	task automatic go(input csb_op_t o, input logic [15:0] p);
		logic        c;
		logic [15:0] ep;
		int          en;
		c = cond(o, ef);
		if (o >= CSB_OP_BRANCH_FLAG_SET) begin
			ep = c ? p + {{9{ofs[6]}}, ofs} + 16'h0001 : p + 16'h0001;
			en = c ? 2 : 1;
		end else begin
			ep = !c ? p + 16'h0001 : (long_next(p) ? p + 16'h0003 : p + 16'h0002);
			en = !c ? 1 : (long_next(p) ? 3 : 2);
		end
		run(o, p, c, ep, en);
	endtask

	// Subtract without store; carry-chained compare keeps Z only if set
	task automatic cmp(input csb_op_t o, input logic [15:0] ab);
		logic       uc;
		logic [8:0] d;
		logic [7:0] r;
		rd = ab[15:8];
		rr = ab[7:0];
		uc = (o == CSB_OP_COMPARE_REGS_WITH_CARRY);
		d = {1'b0, rd} - {1'b0, rr} - {8'h00, uc & ef[`CSB_FLAG_C]};
		r = d[7:0];
		ef[`CSB_FLAG_C] = d[8];
		ef[`CSB_FLAG_Z] = (r == 8'h00) & (!uc | ef[`CSB_FLAG_Z]);
		ef[`CSB_FLAG_N] = r[7];
		ef[`CSB_FLAG_V] = (rd[7] & !rr[7] & !r[7]) | (!rd[7] & rr[7] & r[7]);
		ef[`CSB_FLAG_S] = ef[`CSB_FLAG_N] ^ ef[`CSB_FLAG_V];
		ef[`CSB_FLAG_H] = (!rd[3] & rr[3]) | (rr[3] & r[3]) | (r[3] & !rd[3]);
		run(o, 16'h0005, 1'b0, 16'h0006, 1);
	endtask

	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{arst_n, start, flags_load, rd, rr, io, flags_in, bs, ofs, pc, ef} = '0;
		op = CSB_OP_NONE;
		repeat (3) @(posedge mclk);
		@(negedge mclk);
		arst_n = 1'b1;
		check("reset pc", pc_out, `CSB_PC_RST);
		check("reset state", {5'h0, busy, done, taken, flags}, 16'h0000);
		// Compares, with T and I set so they must survive
		load_flags(8'hc0);
		for (int k = 0; k < 6; k++) begin
			cmp(CSB_OP_COMPARE_REGS, cv[k]);
			cmp(CSB_OP_COMPARE_REGS_WITH_CARRY, cv[k]);
			cmp(CSB_OP_COMPARE_IMMEDIATE, cv[k]);
		end
		// Every flag index, set and clear, backward offset
		ofs = 7'h40;
		for (int s = 0; s < 8; s++) begin
			for (int v = 0; v < 2; v++) begin
				load_flags(v[0] ? 8'h01 << s : ~(8'h01 << s));
				bs = s[2:0];
				go(CSB_OP_BRANCH_FLAG_SET, 16'h0100);
				go(CSB_OP_BRANCH_FLAG_CLEAR, 16'h0100);
			end
		end
		// Named flag branches, forward offset wrapping past the top
		ofs = 7'h3f;
		for (int f = 0; f < 4; f++) begin
			load_flags(f[7:0]);
			for (int o = CSB_OP_BRANCH_ZERO_SET; o <= CSB_OP_BRANCH_SAME_HIGHER; o++) begin
				go(csb_op_t'(o), 16'hffd0);
			end
		end
		// Bit skips over every bit, next word short or long
		rr = 8'h5a;
		io = 8'ha5;
		for (int b = 0; b < 8; b++) begin
			bs = b[2:0];
			for (int o = CSB_OP_SKIP_REG_BIT_CLEAR; o <= CSB_OP_SKIP_IO_BIT_SET; o++) begin
				go(csb_op_t'(o), 16'h0020 + b[15:0]);
			end
		end
		// Equal skip, both word sizes, then unequal
		rd = 8'h33;
		rr = 8'h33;
		go(CSB_OP_COMPARE_SKIP_EQUAL, 16'h0040);
		go(CSB_OP_COMPARE_SKIP_EQUAL, 16'h0041);
		rr = 8'h34;
		go(CSB_OP_COMPARE_SKIP_EQUAL, 16'h0042);
		// The idle code must be ignored: no pulse, pc left as it was
		@(negedge mclk);
		start = 1'b1;
		op = CSB_OP_NONE;
		pc = 16'h0200;
		@(negedge mclk);
		start = 1'b0;
		check("none done", {14'h0, busy, done}, 16'h0000);
		check("none pc", pc_out, 16'h0043);
		// A compare beside a core flag write keeps its own flags, T and I come from the write
		rd = 8'h10;
		rr = 8'h10;
		@(negedge mclk);
		start = 1'b1;
		op = CSB_OP_COMPARE_REGS;
		pc = 16'h0300;
		flags_load = 1'b1;
		flags_in = 8'hfd;
		@(negedge mclk);
		start = 1'b0;
		flags_load = 1'b0;
		check("load clash done", {15'h0, done}, 16'h0001);
		check("load clash pc", pc_out, 16'h0301);
		check("load clash flags", {8'h00, flags}, 16'h00c2);
		wrap_up();
	end
endmodule // tb_compare_skip_branch_unit
